/* src/fes_sequencer.sv */
/*
  Flash erase command sequencer: decodes host command writes, runs bulk
  and sector erase, the latter with appending window, suspend and resume, and gates
  protected sectors. Assumes the address decoder supplies one-hot sector
  selects in the same clock domain, and that the array itself performs
  pre-program and erase when told by the preprog_q and erasing_q levels.
*/
`default_nettype none
module fes_sequencer #(
  parameter int WINDOW_CYCLES = fes_pkg::WINDOW_CYC,
  parameter int ERASE_CYCLES  = fes_pkg::ERASE_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire fes_pkg::fes_bus_t   bus,
  input  wire logic [7:0]          prot_bits,
  input  wire logic                erase_fail,
  output logic [7:0]               prot_rd_q,
  output fes_pkg::fes_rd_t         rd_q,
  output logic [7:0]               erase_mask_q,
  output logic                     preprog_q,
  output logic                     erasing_q,
  output logic [7:0]               invalid_mask_q,
  output logic                     busy
);
  import fes_pkg::*;

  localparam logic [7:0] ST_WIN_BIT = 8'h00_08;

  fes_state_t  state_q;
  logic [2:0]  step_q;
  logic [31:0] tmr_q;
  logic [2:0]  tries_q;
  logic        err_q;
  logic        tog_q;
  logic        bulk_q;
  logic [7:0]  active_sel;
  logic        any_sel;
  logic        wr_cmd;

  function automatic logic [7:0] unprot(input logic [7:0] s, input logic [7:0] p);
    unprot = s & ~p;
  endfunction

  assign any_sel    = |bus.sel;
  assign active_sel = unprot(bus.sel, prot_bits);
  assign wr_cmd     = bus.wr && any_sel;
  assign busy       = (state_q == FES_ERASE) || (state_q == FES_BULK) || (state_q == FES_WINDOW);

  // Expected byte of the five-write erase prefix at each step, then CMD_SECTOR as the sixth
  function automatic logic [7:0] seq_byte(input logic [2:0] s);
    case (s)
      3'd0: seq_byte = CMD_AA;
      3'd1: seq_byte = CMD_55;
      3'd2: seq_byte = CMD_ERASE;
      3'd3: seq_byte = CMD_AA;
      3'd4: seq_byte = CMD_55;
      default: seq_byte = CMD_SECTOR;
    endcase
  endfunction

  // Command state machine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q      <= FES_READ;
      step_q       <= 3'd0;
      tmr_q        <= 32'd0;
      erase_mask_q <= 8'h00_00;
      bulk_q       <= 1'b0;
      tries_q      <= 3'd0;
    end else begin
      case (state_q)
        FES_READ: begin
          if (wr_cmd && bus.data == CMD_AA) begin
            state_q <= FES_COLLECT;
            step_q  <= 3'd1;
          end
        end
        FES_COLLECT: begin
          if (wr_cmd) begin
            if (step_q == 3'd5 && bus.data == CMD_BULK) begin
              if (unprot(8'h00_FF, prot_bits) != 8'h00_00) begin
                erase_mask_q <= unprot(8'h00_FF, prot_bits);
                bulk_q       <= 1'b1;
                tmr_q        <= 32'd0;
                tries_q      <= 3'd0;
                state_q      <= FES_BULK;
              end else begin
                state_q <= FES_READ;
              end
            end else if (step_q == 3'd5 && bus.data == CMD_SECTOR) begin
              erase_mask_q <= active_sel;
              tmr_q        <= 32'd0;
              state_q      <= FES_WINDOW;
            end else if (bus.data == seq_byte(step_q)) begin
              step_q <= step_q + 3'd1;
            end else begin
              state_q <= FES_READ;
            end
          end
        end
        FES_WINDOW: begin
          if (wr_cmd && bus.data == CMD_SECTOR) begin
            erase_mask_q <= erase_mask_q | active_sel;
            tmr_q        <= 32'd0;
          end else if (wr_cmd && bus.data == CMD_SUSPEND) begin
            tmr_q   <= 32'd0;
            state_q <= FES_SUSPING;
          end else if (wr_cmd) begin
            erase_mask_q <= 8'h00_00;
            state_q      <= FES_READ;
          end else if (tmr_q >= 32'(WINDOW_CYCLES - 1)) begin
            tmr_q   <= 32'd0;
            tries_q <= 3'd0;
            bulk_q  <= 1'b0;
            state_q <= (erase_mask_q == 8'h00_00) ? FES_READ : FES_ERASE;
          end else begin
            tmr_q <= tmr_q + 32'd1;
          end
        end
        FES_ERASE, FES_BULK: begin
          if (state_q == FES_ERASE && wr_cmd && bus.data == CMD_SUSPEND) begin
            tmr_q   <= 32'd0;
            state_q <= FES_SUSPING;
          end else if (state_q == FES_ERASE && wr_cmd && bus.data == CMD_RESET) begin
            erase_mask_q <= 8'h00_00;
            state_q      <= FES_READ;
          end else if (tmr_q >= 32'(ERASE_CYCLES - 1)) begin
            tmr_q <= 32'd0;
            if (erase_fail && tries_q != 3'(MAX_TRIES - 1)) begin
              tries_q <= tries_q + 3'd1;
            end else begin
              erase_mask_q <= 8'h00_00;
              state_q      <= FES_READ;
            end
          end else begin
            tmr_q <= tmr_q + 32'd1;
          end
        end
        FES_SUSPING: begin
          if (tmr_q >= 32'(SUSP_CYC - 1)) begin
            state_q <= FES_SUSPEND;
          end else begin
            tmr_q <= tmr_q + 32'd1;
          end
        end
        FES_SUSPEND: begin
          if (wr_cmd && bus.data == CMD_RESUME) begin
            tmr_q   <= 32'd0;
            state_q <= FES_ERASE;
          end else if (wr_cmd && bus.data == CMD_RESET) begin
            erase_mask_q <= 8'h00_00;
            state_q      <= FES_READ;
          end
        end
        default: state_q <= FES_READ;
      endcase
    end
  end

  // Sectors left invalid by an erase aborted with the reset command, running or suspended
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      invalid_mask_q <= 8'h00_00;
    end else if (state_q == FES_SUSPEND && wr_cmd && bus.data == CMD_RESET) begin
      invalid_mask_q <= invalid_mask_q | erase_mask_q;
    end else if (state_q == FES_ERASE && wr_cmd && bus.data == CMD_RESET) begin
      invalid_mask_q <= invalid_mask_q | erase_mask_q;
    end else if (state_q == FES_ERASE && tmr_q == 32'd0) begin
      invalid_mask_q <= invalid_mask_q & ~erase_mask_q;
    end else if (state_q == FES_BULK && tmr_q == 32'd0) begin
      invalid_mask_q <= invalid_mask_q & ~erase_mask_q;
    end
  end

  // Error flag: set on final failed retry, cleared by reset command outside bulk erase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err_q <= 1'b0;
    end else if ((state_q == FES_ERASE || state_q == FES_BULK) && tmr_q >= 32'(ERASE_CYCLES - 1)
                 && erase_fail && tries_q == 3'(MAX_TRIES - 1)) begin
      err_q <= 1'b1;
    end else if (wr_cmd && bus.data == CMD_RESET && state_q != FES_BULK) begin
      err_q <= 1'b0;
    end
  end

  // Array drive: first 32768 cycles of each erase pass (tmr_q[15] low) pre-program to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      preprog_q <= 1'b0;
      erasing_q <= 1'b0;
    end else begin
      preprog_q <= (state_q == FES_ERASE || state_q == FES_BULK) && !tmr_q[15];
      erasing_q <= (state_q == FES_ERASE || state_q == FES_BULK) && tmr_q[15];
    end
  end

  // Toggle bit flips on each status read with a sector selected while busy or suspending
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tog_q <= 1'b0;
    end else if (bus.rd && any_sel && (busy || state_q == FES_SUSPING)) begin
      tog_q <= ~tog_q;
    end
  end

  // Read answer, one cycle after the read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_q      <= '0;
      prot_rd_q <= 8'h00_00;
    end else begin
      prot_rd_q                   <= prot_bits;
      rd_q.status_en              <= bus.rd && (busy || state_q == FES_SUSPING);
      rd_q.status                 <= 8'h00_00;
      rd_q.status[BIT_POLL]       <= 1'b0;
      rd_q.status[BIT_TOGGLE]     <= tog_q;
      rd_q.status[BIT_ERROR]      <= err_q;
      rd_q.status[BIT_WINDOW]     <= (state_q != FES_WINDOW);
      rd_q.array_valid            <= bus.rd && !busy && state_q != FES_SUSPING
                                     && ((bus.sel & (invalid_mask_q
                                     | ((state_q == FES_SUSPEND) ? erase_mask_q : 8'h00_00))) == 8'h00_00);
    end
  end

  logic unused_ok;
  assign unused_ok = ^{bus.addr_lo, ST_WIN_BIT, bulk_q, ERASED_VAL, PREPROG_VAL, NUM_SECTORS};
endmodule
`default_nettype wire

/* src/fes_pkg.sv */
/*
  Package for the flash erase sequencer: command codes, status bit
  positions, sequencer states, timing counts and carrier structs.
  Assumes a 250 MHz clock and a byte-wide host write/read port.
*/
`default_nettype none
package fes_pkg;
  localparam int          NUM_SECTORS = 8;
  localparam logic [7:0]  CMD_AA      = 8'h00_AA;
  localparam logic [7:0]  CMD_55      = 8'h00_55;
  localparam logic [7:0]  CMD_ERASE   = 8'h00_80;
  localparam logic [7:0]  CMD_BULK    = 8'h00_10;
  localparam logic [7:0]  CMD_SECTOR  = 8'h00_30;
  localparam logic [7:0]  CMD_SUSPEND = 8'h00_B0;
  localparam logic [7:0]  CMD_RESUME  = 8'h00_30;
  localparam logic [7:0]  CMD_RESET   = 8'h00_F0;
  localparam logic [7:0]  PREPROG_VAL = 8'h00_00;
  localparam logic [7:0]  ERASED_VAL  = 8'h00_FF;
  localparam int          BIT_POLL    = 7;
  localparam int          BIT_TOGGLE  = 6;
  localparam int          BIT_ERROR   = 5;
  localparam int          BIT_WINDOW  = 3;
  localparam int          CLK_MHZ     = 250;
  localparam int          WINDOW_US   = 100;
  localparam int          WINDOW_CYC  = WINDOW_US * CLK_MHZ;
  localparam int          SUSP_MIN_NS = 100;
  localparam int          SUSP_CYC    = (SUSP_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int          ERASE_CYC   = 65536;
  localparam int          MAX_TRIES   = 4;

  typedef enum logic [2:0] {
    FES_READ    = 3'b000,
    FES_COLLECT = 3'b001,
    FES_WINDOW  = 3'b010,
    FES_ERASE   = 3'b011,
    FES_SUSPEND = 3'b100,
    FES_BULK    = 3'b101,
    FES_SUSPING = 3'b110
  } fes_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr_lo;
    logic [7:0] data;
    logic [7:0] sel;
  } fes_bus_t;

  typedef struct packed {
    logic       status_en;
    logic [7:0] status;
    logic       array_valid;
  } fes_rd_t;
endpackage
`default_nettype wire

/* test/fes_seq_properties.sv */
/* Checker of the erase sequencer's port behaviour.
   Bound to fes_sequencer; sees only its ports. */
`default_nettype none
module fes_seq_properties
  import fes_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire fes_pkg::fes_bus_t bus,
  input wire logic [7:0]        prot_bits,
  input wire logic [7:0]        prot_rd_q,
  input wire fes_pkg::fes_rd_t  rd_q,
  input wire logic [7:0]        erase_mask_q,
  input wire logic              preprog_q,
  input wire logic              erasing_q,
  input wire logic              busy
);
  logic run;
  logic sec_cmd;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  assign run = preprog_q || erasing_q;
  // A select-qualified write while a sector erase pass is running
  assign sec_cmd = bus.wr && (|bus.sel) && run && (erase_mask_q != 8'h00FF);
  a_read_answer_cause: assert property ((rd_q.status_en || rd_q.array_valid) |-> $past(bus.rd))
    else $error("read answer without a read strobe");
  a_poll_low_run: assert property (bus.rd && run |=> rd_q.status_en && !rd_q.status[BIT_POLL])
    else $error("polling bit not low during erase");
  a_toggle_flips: assert property (rd_q.status_en && $past(rd_q.status_en) && $past(run) && $past(run, 2)
    |-> rd_q.status[BIT_TOGGLE] != $past(rd_q.status[BIT_TOGGLE]))
    else $error("toggle bit did not invert");
  a_prot_copy_seen: assert property (!$past(rst, 3) && $stable(prot_bits) |-> prot_rd_q == prot_bits)
    else $error("protection readback wrong");
  a_prot_never_erased: assert property (busy && $stable(prot_bits) |-> (erase_mask_q & prot_bits) == 8'h0000)
    else $error("protected sector targeted");
  a_preprog_before_erase: assert property ($rose(erasing_q) |-> $past(preprog_q))
    else $error("erase phase without pre-program");
  a_suspend_stops_run: assert property (sec_cmd && bus.data == CMD_SUSPEND |-> ##[1:1000] !run)
    else $error("suspend did not stop erase");
  a_reset_aborts_sector: assert property (sec_cmd && bus.data == CMD_RESET |-> ##[1:8] !busy)
    else $error("reset did not abort sector erase");
endmodule
bind fes_sequencer fes_seq_properties chk_u (.clk(clk), .rst(rst), .bus(bus), .prot_bits(prot_bits),
  .prot_rd_q(prot_rd_q), .rd_q(rd_q), .erase_mask_q(erase_mask_q), .preprog_q(preprog_q),
  .erasing_q(erasing_q), .busy(busy));
`default_nettype wire

/* test/fes_host.sv */
/* Host processor model on the byte-wide bus.
   Assumes the bench calls its tasks after reset release. */
`default_nettype none
module fes_host
  import fes_pkg::*;
(
  input  wire logic              clk,
  input  wire fes_pkg::fes_rd_t  rd_q,
  output var  fes_pkg::fes_bus_t bus
);
  timeunit 1ns;
  timeprecision 1ps;
  initial bus = '0;
  task automatic wr(input logic [7:0] s, input logic [7:0] d);
    @(posedge clk);
    bus.wr <= 1'b1;
    bus.sel <= s;
    bus.data <= d;
    @(posedge clk);
    bus.wr <= 1'b0;
    bus.sel <= 8'h0000;
    bus.data <= ~d; // Released lines show no stale byte
  endtask
  task automatic cmd6(input logic [7:0] s, input logic [7:0] last);
    logic [7:0] seq [5] = '{CMD_AA, CMD_55, CMD_ERASE, CMD_AA, CMD_55};
    foreach (seq[i]) wr(s, seq[i]);
    wr(s, last);
  endtask
  // Two back-to-back reads; each answer is taken in its own cycle
  task automatic rd2(input logic [7:0] s, output fes_pkg::fes_rd_t a, output fes_pkg::fes_rd_t b);
    @(posedge clk);
    bus.rd <= 1'b1;
    bus.sel <= s;
    @(posedge clk);
    #1 a = rd_q;
    @(posedge clk);
    bus.rd <= 1'b0;
    bus.sel <= 8'h0000;
    #1 b = rd_q;
  endtask
endmodule
`default_nettype wire

/* test/fes_sequencer_tb_top.sv */
/* Self-checking bench of the erase sequencer.
   Assumes fes_host drives the bus and the checker is bound. */
`default_nettype none
module fes_sequencer_tb_top
  import fes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk;
  logic              rst;
  logic [7:0]        prot_bits;
  logic              erase_fail;
  fes_bus_t          bus;
  fes_rd_t           rd_q;
  fes_rd_t           a;
  fes_rd_t           b;
  logic [7:0]        prot_rd_q;
  logic [7:0]        erase_mask_q;
  logic [7:0]        invalid_mask_q;
  logic              preprog_q;
  logic              erasing_q;
  logic              busy;
  int                fail_count = 0;
  int                tests_run = 0;
  int                cycles = 0;
  fes_sequencer #(.WINDOW_CYCLES(50), .ERASE_CYCLES(40000)) dut_u (.clk(clk), .rst(rst), .bus(bus),
    .prot_bits(prot_bits), .erase_fail(erase_fail), .prot_rd_q(prot_rd_q), .rd_q(rd_q),
    .erase_mask_q(erase_mask_q), .preprog_q(preprog_q), .erasing_q(erasing_q), .invalid_mask_q(invalid_mask_q),
    .busy(busy));
  fes_host host_u (.clk(clk), .rd_q(rd_q), .bus(bus));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic t_abort();
    host_u.cmd6(8'h01, 8'h11);
    settle(2);
    check("busy", {7'h00, busy}, 8'h00);
    host_u.cmd6(8'h01, CMD_SECTOR);
    settle(1);
    check("busy", {7'h00, busy}, 8'h01);
    host_u.wr(8'h01, CMD_AA);
    settle(2);
    check("busy", {7'h00, busy}, 8'h00);
  endtask
  task automatic t_sector();
    host_u.cmd6(8'h04, CMD_SECTOR);
    host_u.wr(8'h20, CMD_SECTOR);
    host_u.rd2(8'h04, a, b);
    check("window", {7'h00, a.status[BIT_WINDOW]}, 8'h00);
    check("status_en", {7'h00, a.status_en}, 8'h01);
    settle(60);
    host_u.rd2(8'h04, a, b);
    check("window", {7'h00, a.status[BIT_WINDOW]}, 8'h01);
    check("poll", {7'h00, a.status[BIT_POLL]}, 8'h00);
    check("toggle", {7'h00, a.status[BIT_TOGGLE] ^ b.status[BIT_TOGGLE]}, 8'h01);
    check("mask", erase_mask_q, 8'h0024);
    host_u.wr(8'h04, CMD_SUSPEND);
    settle(40);
    host_u.rd2(8'h04, a, b);
    check("toggle", {7'h00, a.status[BIT_TOGGLE] ^ b.status[BIT_TOGGLE]}, 8'h00);
    check("valid", {7'h00, a.array_valid}, 8'h00);
    host_u.rd2(8'h01, a, b);
    check("valid", {7'h00, a.array_valid}, 8'h01);
    host_u.wr(8'h04, CMD_RESUME);
    settle(2);
    check("busy", {7'h00, busy}, 8'h01);
    host_u.wr(8'h04, CMD_RESET);
    settle(4);
    check("busy", {7'h00, busy}, 8'h00);
    check("invalid", invalid_mask_q, 8'h24);
  endtask
  task automatic t_prot();
    @(posedge clk);
    prot_bits <= 8'h0002;
    settle(3);
    check("prot", prot_rd_q, 8'h0002);
    host_u.cmd6(8'h02, CMD_SECTOR);
    settle(2);
    check("mask", erase_mask_q & 8'h0002, 8'h0000);
    host_u.wr(8'h02, CMD_RESET);
    @(posedge clk);
    prot_bits <= 8'h0000;
  endtask
  task automatic t_bulk();
    int n;
    n = 0;
    host_u.cmd6(8'h80, CMD_BULK);
    settle(3);
    check("preprog", {7'h00, preprog_q}, 8'h01);
    check("mask", erase_mask_q, 8'h00FF);
    host_u.wr(8'h80, CMD_RESET);
    settle(2);
    check("busy", {7'h00, busy}, 8'h01);
    host_u.rd2(8'h80, a, b);
    check("poll", {7'h00, a.status[BIT_POLL]}, 8'h00);
    while (busy === 1'b1 && n < 50000) begin
      settle(1);
      n++;
    end
    check("busy", {7'h00, busy}, 8'h00);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    rst = 1'b1;
    prot_bits = 8'h0000;
    erase_fail = 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    t_abort();
    t_sector();
    t_prot();
    t_bulk();
    wrap_up();
  end
endmodule
`default_nettype wire
